/* rtl/lfu_consts.svh */
// offsets, field positions, reset values and format codes of the window write unpacker
// assumes byte addresses on the register bus and 32-bit aligned words
`ifndef LFU_CONSTS_SVH
`define LFU_CONSTS_SVH
// window select and pixel address fields
`define LFU_WIN_BIT 21
`define LFU_ROW_LSB 11
`define LFU_X_W 10
`define LFU_Y_W 10
`define LFU_SCREEN_H 480
// register offsets inside the register page
`define LFU_OFS_WCTL 21'h000000
`define LFU_OFS_PBC 21'h000004
`define LFU_OFS_CDA 21'h000008
`define LFU_OFS_STAT 21'h00000c
// reset values
`define LFU_WCTL_RST 32'h00000000
`define LFU_PBC_RST 32'h00000000
`define LFU_CDA_RST 32'h00000000
// framebuffer_write_control fields
`define LFU_WC_FMT 3:0
`define LFU_WC_PIPE 8
`define LFU_WC_LANE 10:9
`define LFU_WC_SWAP 11
`define LFU_WC_SWZ 12
`define LFU_WC_YORG 13
`define LFU_WC_WSEL 14
// pixel_buffer_control fields
`define LFU_PB_DITHER 8
`define LFU_PB_YORG 17
`define LFU_PB_ABUF 18
// constant depth/alpha fields
`define LFU_CDA_Z 15:0
`define LFU_CDA_W 23:0
`define LFU_CDA_A 31:24
// write format codes
`define LFU_F565 4'h0
`define LFU_F555 4'h1
`define LFU_F1555 4'h2
`define LFU_FX888 4'h4
`define LFU_F8888 4'h5
`define LFU_FZ32 4'h8
`define LFU_FVMP 4'h9
`define LFU_FZ565 4'hc
`define LFU_FZ555 4'hd
`define LFU_FZ1555 4'he
`define LFU_FZZ 4'hf
`endif

/* rtl/lfu_pkg.sv */
// types shared by the window write unpacker
// assumes lfu_consts.svh on the include path
`include "lfu_consts.svh"
package lfu_pkg;
  // controller states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PIX = 4'b0010,
    S_VMP = 4'b0100,
    S_ACK = 4'b1000
  } lfu_state_t;
  // one unpacked pixel towards pipeline or buffers
  typedef struct packed {
    logic [`LFU_X_W-1:0] x;
    logic [`LFU_Y_W-1:0] y;
    logic [31:0] argb;
    logic [31:0] depth;
    logic [23:0] w;
    logic color_we;
    logic depth_we;
    logic alpha_we;
    logic dither;
  } lfu_pix_t;
  // one queued word for the video module port
  typedef struct packed {
    logic [`LFU_WIN_BIT-1:0] addr;
    logic [31:0] data;
  } lfu_vmp_t;
endpackage

/* rtl/lfu_unpack16.sv */
// unpacks one 16-bit colour half into 8-bit argb
// assumes half already swizzled and half-swapped; purely combinational
module lfu_unpack16
  import lfu_pkg::*;
(
  input wire logic [15:0] half,
  input wire logic [1:0] fmt2,
  input wire logic [1:0] lanes,
  output logic [31:0] argb
);
  logic [4:0] c_hi;
  logic [5:0] g6;
  logic [4:0] c_lo;
  logic a1;

  // field split by format and lane layout, then widen by replication
  always_comb
  begin
    c_hi = half[15:11];
    g6 = half[10:5];
    c_lo = half[4:0];
    a1 = 1'b0;
    if (fmt2 != 2'h0)
    begin
      if (!lanes[1])
      begin
        a1 = half[15];
        c_hi = half[14:10];
        g6 = {half[9:5], half[9]};
        c_lo = half[4:0];
      end
      else
      begin
        c_hi = half[15:11];
        g6 = {half[10:6], half[10]};
        c_lo = half[5:1];
        a1 = half[0];
      end
    end
    argb[31:24] = {8{a1 & (fmt2 == 2'h2)}};
    argb[15:8] = {g6, g6[5:4]};
    // lane bit 0 puts blue in the upper field
    if (lanes[0])
    begin
      argb[23:16] = {c_lo, c_lo[4:2]};
      argb[7:0] = {c_hi, c_hi[4:2]};
    end
    else
    begin
      argb[23:16] = {c_hi, c_hi[4:2]};
      argb[7:0] = {c_lo, c_lo[4:2]};
    end
  end
endmodule

/* rtl/lfu_top.sv */
// window write unpacker: avalon slave, write control registers, pixel unpack
// assumes the pixel pipeline, buffer writer and video port share core_clk
//
// Operation
// - accept formats 0-2, 4, 5, 8, 9, 12-15
// - format 9 goes to video module port
// - pixel x,y from window address offset
// - pipeline mode: pixel carries depth, alpha, full processing
// - bypass mode: unconditional write, only dither applied
// - bypass updates only buffers the format holds
// - bypass formats 0-2, 4 never touch depth
// - bypass formats 12, 13 write colour and depth; 14 writes colour and depth only without alpha buffer
// - bypass format 15 writes depth only
// - bypass alpha stored only with alpha buffer
// - bypass format 14 drops depth or alpha
// - pipeline fills missing depth/alpha from constant
// - lane field picks ARGB, ABGR, RGBA, BGRA
// - formats 0-2 pack two pixels, swap reverses
// - formats 12-14 depth high, swap reverses
// - format 15 unswapped: right high, left low
// - swizzle bit enables byte swizzle
// - Y origin bit flips row zero
// - W from depth or constant bits 23:0
// - swizzle exchanges outer and inner byte pairs
// - swizzle, then half swap, then lanes
// - half swap ignored for formats 4, 5, 8
// - format 15 swapped: left high, right low
`include "lfu_consts.svh"
module lfu_top
  import lfu_pkg::*;
#(
  parameter int ADDR_W = `LFU_WIN_BIT + 1,
  parameter int SCREEN_H = `LFU_SCREEN_H
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic pipe_valid,
  output lfu_pkg::lfu_pix_t pipe_pix,
  input wire logic pipe_ready,
  output logic buf_valid,
  output lfu_pkg::lfu_pix_t buf_pix,
  input wire logic buf_ready,
  output logic vmp_valid,
  output lfu_pkg::lfu_vmp_t vmp_word,
  input wire logic vmp_ready
);
  import lfu_pkg::*;

  // ************************************************************
  // parameter checks and state
  // ************************************************************
  if (ADDR_W != `LFU_WIN_BIT + 1)
  begin : g_bad_addr
    $error("address width must be one above the window select bit");
  end
  if (SCREEN_H < 1 || SCREEN_H > (1 << `LFU_Y_W))
  begin : g_bad_h
    $error("screen height does not fit the row field");
  end

  typedef struct packed {
    lfu_state_t state;
    logic waitreq;
    logic [31:0] rdata;
    logic [31:0] ctl;
    logic [31:0] pbc;
    logic [31:0] cda;
    logic [15:0] drop_cnt;
    logic [15:0] wr_cnt;
    logic [31:0] word;
    logic [`LFU_WIN_BIT-1:0] off;
    logic beat;
    logic pipe_v;
    logic buf_v;
    lfu_pix_t pix;
    logic vmp_v;
    lfu_vmp_t vmp;
  } lfu_top_st_t;

  lfu_top_st_t s_r;
  lfu_top_st_t s_nxt;

  logic [3:0] fmt;
  logic pipe_en;
  logic is_win;
  logic fmt_ok;
  logic swap_ok;
  logic two_pix;
  logic has_a;
  logic has_z;
  logic bsel;
  logic out_fire;
  logic [31:0] wd_rev;
  logic [31:0] sw_in;
  logic [31:0] cw;
  logic [31:0] hs;
  logic [31:0] c32;
  logic [31:0] left_argb;
  logic [31:0] right_argb;
  logic [31:0] rd_mux;
  logic [`LFU_WIN_BIT-1:0] co;
  logic [`LFU_Y_W-1:0] yraw;
  lfu_pix_t px;

  // byte-lane merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // write data path: swizzle, half swap, lane select
  // ************************************************************
  assign fmt = s_r.ctl[`LFU_WC_FMT];
  assign pipe_en = s_r.ctl[`LFU_WC_PIPE];
  assign is_win = avs_address[`LFU_WIN_BIT];
  assign wd_rev = {avs_writedata[7:0], avs_writedata[15:8], avs_writedata[23:16],
                   avs_writedata[31:24]};
  assign sw_in = s_r.ctl[`LFU_WC_SWZ] ? wd_rev : avs_writedata;
  assign cw = (s_r.state == S_IDLE) ? sw_in : s_r.word;
  assign co = (s_r.state == S_IDLE) ? avs_address[`LFU_WIN_BIT-1:0] : s_r.off;
  assign swap_ok = s_r.ctl[`LFU_WC_SWAP] &&
                   !(fmt == `LFU_FX888 || fmt == `LFU_F8888 || fmt == `LFU_FZ32);
  assign hs = swap_ok ? {cw[15:0], cw[31:16]} : cw;
  assign two_pix = (fmt <= `LFU_F1555) || (fmt == `LFU_FZZ);
  assign has_a = fmt == `LFU_F1555 || fmt == `LFU_F8888 || fmt == `LFU_FZ1555;
  assign has_z = fmt == `LFU_FZ32 || fmt >= `LFU_FZ565;
  assign bsel = s_r.state != S_IDLE;
  assign out_fire = (s_r.pipe_v && pipe_ready) || (s_r.buf_v && buf_ready);
  assign yraw = co[`LFU_WIN_BIT-1:`LFU_ROW_LSB];

  // format acceptance
  always_comb
  begin
    case (fmt)
      `LFU_F565, `LFU_F555, `LFU_F1555, `LFU_FX888, `LFU_F8888, `LFU_FZ32, `LFU_FVMP,
      `LFU_FZ565, `LFU_FZ555, `LFU_FZ1555, `LFU_FZZ: fmt_ok = 1'b1;
      default: fmt_ok = 1'b0;
    endcase
  end

  // colour halves: low half is the left pixel or the colour of a depth pair
  lfu_unpack16 u_left (
    .half(hs[15:0]),
    .fmt2(fmt[1:0]),
    .lanes(s_r.ctl[`LFU_WC_LANE]),
    .argb(left_argb)
  );
  lfu_unpack16 u_right (
    .half(hs[31:16]),
    .fmt2(fmt[1:0]),
    .lanes(s_r.ctl[`LFU_WC_LANE]),
    .argb(right_argb)
  );

  // 32-bit lane order for formats 4 and 5
  always_comb
  begin
    case (s_r.ctl[`LFU_WC_LANE])
      2'h0: c32 = cw;
      2'h1: c32 = {cw[31:24], cw[7:0], cw[15:8], cw[23:16]};
      2'h2: c32 = {cw[7:0], cw[31:8]};
      default: c32 = {cw[7:0], cw[15:8], cw[23:16], cw[31:24]};
    endcase
  end

  // ************************************************************
  // pixel build for the current beat
  // ************************************************************
  always_comb
  begin
    px = '0;
    // two-pixel formats step x by one per beat
    if (two_pix)
    begin
      px.x = {co[`LFU_ROW_LSB-1:2], bsel};
    end
    else
    begin
      px.x = {1'b0, co[`LFU_ROW_LSB-1:2]};
    end
    // origin bit of the active path decides row order
    if ((pipe_en && s_r.pbc[`LFU_PB_YORG]) || (!pipe_en && s_r.ctl[`LFU_WC_YORG]))
    begin
      px.y = `LFU_Y_W'(SCREEN_H - 1) - yraw;
    end
    else
    begin
      px.y = yraw;
    end
    // colour source
    case (fmt)
      `LFU_FX888: px.argb = {8'h00, c32[23:0]};
      `LFU_F8888: px.argb = c32;
      `LFU_FZ32, `LFU_FZZ: px.argb = '0;
      default: px.argb = (two_pix && bsel) ? right_argb : left_argb;
    endcase
    // depth source
    case (fmt)
      `LFU_FZ32: px.depth = hs;
      `LFU_FZ565, `LFU_FZ555, `LFU_FZ1555: px.depth = {16'h0000, hs[31:16]};
      `LFU_FZZ: px.depth = {16'h0000, bsel ? hs[31:16] : hs[15:0]};
      default: px.depth = '0;
    endcase
    if (pipe_en)
    begin
      // pipeline path: full pixel, masks and tests applied downstream
      if (!has_a)
      begin
        px.argb[31:24] = s_r.cda[`LFU_CDA_A];
      end
      if (!has_z)
      begin
        px.depth = {16'h0000, s_r.cda[`LFU_CDA_Z]};
      end
      px.color_we = 1'b1;
      px.depth_we = 1'b1;
      px.alpha_we = 1'b1;
      px.dither = s_r.pbc[`LFU_PB_DITHER];
      px.w = s_r.ctl[`LFU_WC_WSEL] ? s_r.cda[`LFU_CDA_W] : px.depth[23:0];
    end
    else
    begin
      // bypass: only the buffers the format holds, masks ignored
      px.color_we = !(fmt == `LFU_FZ32 || fmt == `LFU_FZZ);
      px.depth_we = has_z && !(fmt == `LFU_FZ1555 && s_r.pbc[`LFU_PB_ABUF]);
      px.alpha_we = has_a && s_r.pbc[`LFU_PB_ABUF];
      px.dither = s_r.pbc[`LFU_PB_DITHER];
    end
  end

  // register read mux
  always_comb
  begin
    case (avs_address[`LFU_WIN_BIT-1:0])
      `LFU_OFS_WCTL: rd_mux = s_r.ctl;
      `LFU_OFS_PBC: rd_mux = s_r.pbc;
      `LFU_OFS_CDA: rd_mux = s_r.cda;
      `LFU_OFS_STAT: rd_mux = {s_r.wr_cnt, s_r.drop_cnt};
      default: rd_mux = '0;
    endcase
    if (is_win)
    begin
      rd_mux = '0;
    end
  end

  // ************************************************************
  // bus and transfer controller
  // ************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.waitreq = 1'b1;
    case (s_r.state)
      S_IDLE:
      begin
        if (avs_read)
        begin
          s_nxt.rdata = rd_mux;
          s_nxt.state = S_ACK;
          s_nxt.waitreq = 1'b0;
        end
        else if (avs_write)
        begin
          s_nxt.state = S_ACK;
          s_nxt.waitreq = 1'b0;
          if (is_win)
          begin
            s_nxt.word = sw_in;
            s_nxt.off = co;
            s_nxt.wr_cnt = s_r.wr_cnt + 16'h0001;
            s_nxt.beat = 1'b0;
            if (fmt == `LFU_FVMP)
            begin
              s_nxt.vmp_v = 1'b1;
              s_nxt.vmp = '{addr: co, data: sw_in};
              s_nxt.state = S_VMP;
              s_nxt.waitreq = 1'b1;
            end
            else if (!fmt_ok)
            begin
              s_nxt.drop_cnt = s_r.drop_cnt + 16'h0001;
            end
            else
            begin
              s_nxt.pix = px;
              s_nxt.pipe_v = pipe_en;
              s_nxt.buf_v = !pipe_en;
              s_nxt.state = S_PIX;
              s_nxt.waitreq = 1'b1;
            end
          end
          else
          begin
            case (avs_address[`LFU_WIN_BIT-1:0])
              `LFU_OFS_WCTL: s_nxt.ctl = be_merge(s_r.ctl, avs_writedata, avs_byteenable);
              `LFU_OFS_PBC: s_nxt.pbc = be_merge(s_r.pbc, avs_writedata, avs_byteenable);
              `LFU_OFS_CDA: s_nxt.cda = be_merge(s_r.cda, avs_writedata, avs_byteenable);
              default: s_nxt.rdata = s_r.rdata;
            endcase
          end
        end
      end
      S_PIX:
      begin
        if (out_fire)
        begin
          if (two_pix && !s_r.beat)
          begin
            s_nxt.pix = px;
            s_nxt.beat = 1'b1;
          end
          else
          begin
            s_nxt.pipe_v = 1'b0;
            s_nxt.buf_v = 1'b0;
            s_nxt.state = S_ACK;
            s_nxt.waitreq = 1'b0;
          end
        end
      end
      S_VMP:
      begin
        if (vmp_ready)
        begin
          s_nxt.vmp_v = 1'b0;
          s_nxt.state = S_ACK;
          s_nxt.waitreq = 1'b0;
        end
      end
      S_ACK: s_nxt.state = S_IDLE;
      default: s_nxt.state = S_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.state <= S_IDLE;
      s_r.waitreq <= 1'b1;
      s_r.ctl <= `LFU_WCTL_RST;
      s_r.pbc <= `LFU_PBC_RST;
      s_r.cda <= `LFU_CDA_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;
  assign pipe_valid = s_r.pipe_v;
  assign pipe_pix = s_r.pix;
  assign buf_valid = s_r.buf_v;
  assign buf_pix = s_r.pix;
  assign vmp_valid = s_r.vmp_v;
  assign vmp_word = s_r.vmp;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  chk_reserved_drop: assert property (
    (s_r.state == S_IDLE && avs_write && is_win && !fmt_ok && !avs_read)
      |=> (s_r.state == S_ACK && !s_r.pipe_v && !s_r.buf_v && !s_r.vmp_v))
    else $error("reserved format write reached an output");
  chk_vmp_route: assert property (
    (s_r.state == S_IDLE && avs_write && is_win && fmt == `LFU_FVMP && !avs_read)
      |=> (s_r.vmp_v && !s_r.pipe_v && !s_r.buf_v))
    else $error("video port write not routed");
  chk_bypass_color: assert property (
    (s_r.buf_v && (fmt <= `LFU_F1555 || fmt == `LFU_FX888))
      |-> (s_r.pix.color_we && !s_r.pix.depth_we))
    else $error("colour-only bypass touched depth");
  chk_combo_both: assert property (
    (s_r.buf_v && (fmt == `LFU_FZ565 || fmt == `LFU_FZ555))
      |-> (s_r.pix.color_we && s_r.pix.depth_we))
    else $error("depth plus colour bypass not written");
  chk_fmt15_depth: assert property (
    (s_r.buf_v && fmt == `LFU_FZZ) |-> (!s_r.pix.color_we && s_r.pix.depth_we))
    else $error("depth pair wrote colour");
  chk_fmt14_alpha: assert property (
    (s_r.buf_v && fmt == `LFU_FZ1555)
      |-> (s_r.pix.alpha_we == s_r.pbc[`LFU_PB_ABUF]
           && s_r.pix.depth_we == !s_r.pbc[`LFU_PB_ABUF]))
    else $error("format 14 alpha/depth choice wrong");
  chk_path_select: assert property (
    (s_r.pipe_v || s_r.buf_v) |-> (s_r.pipe_v == pipe_en && s_r.buf_v == !pipe_en))
    else $error("pixel sent on wrong path");
  chk_pair_beats: assert property (
    (s_r.state == S_PIX && out_fire && two_pix && !s_r.beat)
      |=> ((s_r.pipe_v || s_r.buf_v) && s_r.pix.x == $past(s_r.pix.x) + 10'h001))
    else $error("second pixel of a pair missing");
  chk_w_select: assert property (
    (s_r.pipe_v && s_r.ctl[`LFU_WC_WSEL]) |-> (s_r.pix.w == s_r.cda[`LFU_CDA_W]))
    else $error("w not taken from constant");
  chk_swizzle_z32: assert property (
    (s_r.state == S_IDLE && avs_write && is_win && !avs_read && fmt == `LFU_FZ32
     && s_r.ctl[`LFU_WC_SWZ]) |=> (s_r.pix.depth == $past(wd_rev)))
    else $error("byte swizzle not applied");
  chk_bus_ack: assert property (
    (s_r.state == S_IDLE && avs_read) |=> (!s_r.waitreq ##1 s_r.waitreq))
    else $error("read not answered in one cycle");
endmodule

/* test/lfu_sink.sv */
// sink model standing in for the pixel pipeline, buffer writer and video port
// assumes the unpacker holds valid and item until the accepting edge
module lfu_sink
  import lfu_pkg::*;
#(
  parameter type T = lfu_pix_t
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic valid,
  input T item,
  input wire logic stall,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // acceptance and log
  // ****************************************
  logic [1:0] slow_r;
  T got [4];
  int n;
  // stalled, the sink takes only one cycle in four
  assign ready = !stall || (slow_r == 2'h0);
  // accepted items go into a ring of four, n counts them all
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      slow_r <= 2'h0;
      n <= 0;
    end
    else
    begin
      slow_r <= slow_r + 2'h1;
      if (valid && ready)
      begin
        got[2'(n)] <= item;
        n <= n + 1;
      end
    end
  end
endmodule

/* test/test_linear_framebuffer_write_unpacker.sv */
// self-checking bench of the window write unpacker over its avalon slave
// assumes lfu_pkg compiled first and sink models on all three outputs
`define CK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module test_linear_framebuffer_write_unpacker
  import lfu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals and models
  // ****************************************
  logic core_clk, reset, avs_read, avs_write, avs_waitrequest, stall;
  logic [21:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic pipe_valid, pipe_ready, buf_valid, buf_ready, vmp_valid, vmp_ready;
  lfu_pix_t pipe_pix, buf_pix, p0, p1;
  lfu_vmp_t vmp_word;
  int mismatches, checks_done, cyc, bn, pn, vn;
  logic [31:0] lane_exp [4] = '{32'h11223344, 32'h11443322, 32'h44112233, 32'h44332211};
  logic [31:0] zc [3] = '{32'h0000000f, 32'h0000080f, 32'h0000180f};
  logic [31:0] zx [3] = '{32'h33441122, 32'h11223344, 32'h44332211};
  logic [3:0] rsv [5] = '{4'h3, 4'h6, 4'h7, 4'ha, 4'hb};
  logic [31:0] c16 [5] = '{32'h1, 32'h202, 32'h402, 32'h600, 32'h40d};
  logic [31:0] d16 [5] = '{32'h7c00, 32'h801f, 32'h0001, 32'hf800, 32'h003e};
  logic [31:0] e16 [5] = '{32'h00ff0000, 32'hffff0000, 32'hff000000, 32'h000000ff, 32'h000000ff};
  lfu_top dut (.core_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pipe_valid, .pipe_pix, .pipe_ready,
    .buf_valid, .buf_pix, .buf_ready, .vmp_valid, .vmp_word, .vmp_ready);
  lfu_sink #(.T(lfu_pix_t)) sb (.core_clk, .reset, .valid(buf_valid), .item(buf_pix),
    .stall, .ready(buf_ready));
  lfu_sink #(.T(lfu_pix_t)) sp (.core_clk, .reset, .valid(pipe_valid), .item(pipe_pix),
    .stall, .ready(pipe_ready));
  lfu_sink #(.T(lfu_vmp_t)) sv (.core_clk, .reset, .valid(vmp_valid), .item(vmp_word),
    .stall, .ready(vmp_ready));
  // ****************************************
  // clock, watchdog and tasks
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // a hang past the ceiling counts as a mismatch
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [21:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // control word first, then one window write
  task automatic wpix(input logic [31:0] ctl, input logic [21:0] a, input logic [31:0] d);
    bus(1'b1, 22'h0, ctl);
    bn = sb.n;
    pn = sp.n;
    vn = sv.n;
    bus(1'b1, a, d);
    p0 = sb.got[2'(bn)];
    p1 = sb.got[2'(bn + 1)];
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    reset = 1'b1;
    stall = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 22'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    // reset values, read-write constant, unmapped offset
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, 22'(i * 4), 32'h0);
      `CK("reg_reset", 32'h0, q)
    end
    bus(1'b1, 22'h8, 32'h5a123456);
    bus(1'b1, 22'h10, 32'hffffffff);
    bus(1'b0, 22'h8, 32'h0);
    `CK("const_rw", 32'h5a123456, q)
    bus(1'b0, 22'h10, 32'h0);
    `CK("unmapped", 32'h0, q)
    $display("test registers done");
    // 32-bit colour lanes, swizzle, ignored half swap
    for (int l = 0; l < 6; l++)
    begin
      wpix((l < 4) ? 32'h5 | (l << 9) : 32'h1005 | ((l - 4) << 11), 22'h201814, 32'h11223344);
      `CK("nbuf", bn + 1, sb.n)
      `CK("argb", lane_exp[l < 4 ? l : 3], p0.argb)
      `CK("x", 10'd5, p0.x)
      `CK("y", 10'd3, p0.y)
      `CK("zwe", 1'b0, p0.depth_we)
      `CK("awe", 1'b0, p0.alpha_we)
    end
    $display("test lanes done");
    // two 16-bit pixels, stalled sink, swap and row flip
    stall <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      wpix(s ? 32'h2800 : 32'h0, 22'h201800, 32'h0000ffff);
      `CK("nbuf", bn + 2, sb.n)
      `CK("left_lit", s == 0, |p0.argb[23:16])
      `CK("right_lit", s == 1, |p1.argb[23:16])
      `CK("xl", 10'd0, p0.x)
      `CK("xr", 10'd1, p1.x)
      `CK("y", s ? 10'd476 : 10'd3, p0.y)
      `CK("cwe", 1'b1, p0.color_we)
      `CK("zwe", 1'b0, p1.depth_we)
    end
    stall <= 1'b0;
    $display("test pairs done");
    // two depths per word, swap and swizzle order
    for (int c = 0; c < 3; c++)
    begin
      wpix(zc[c], 22'h201800, 32'h11223344);
      `CK("nbuf", bn + 2, sb.n)
      `CK("zl", zx[c][31:16], p0.depth[15:0])
      `CK("zr", zx[c][15:0], p1.depth[15:0])
      `CK("cwe", 1'b0, p0.color_we)
      `CK("zwe", 1'b1, p1.depth_we)
    end
    $display("test depth pairs done");
    // depth plus colour, then alpha buffer choice
    for (int s = 0; s < 2; s++)
    begin
      wpix(32'hc | (s << 11), 22'h201814, s ? 32'h0000beef : 32'hbeef0000);
      `CK("z", 16'hbeef, p0.depth[15:0])
      `CK("cwe", 1'b1, p0.color_we)
      `CK("zwe", 1'b1, p0.depth_we)
    end
    for (int a = 0; a < 2; a++)
    begin
      bus(1'b1, 22'h4, (32'(a) << 18) | (32'(a) << 8));
      wpix(32'he, 22'h201814, 32'hbeef8000);
      `CK("dith", a == 1, p0.dither)
      `CK("zwe", a == 0, p0.depth_we)
      `CK("awe", a == 1, p0.alpha_we)
    end
    bus(1'b1, 22'h4, 32'h0);
    $display("test depth colour done");
    // 16-bit colour layouts, lane orders and alpha bit
    for (int i = 0; i < 5; i++)
    begin
      wpix(c16[i], 22'h201800, d16[i]);
      `CK("argb16", e16[i], p0.argb)
    end
    // 32-bit depth: swizzle applies, half swap ignored
    wpix(32'h1808, 22'h201814, 32'h11223344);
    `CK("z32", 32'h44332211, p0.depth)
    `CK("cwe", 1'b0, p0.color_we)
    `CK("zwe", 1'b1, p0.depth_we)
    $display("test formats done");
    // video port word, then reserved codes dropped
    wpix(32'h9, 22'h201814, 32'h11223344);
    `CK("nvmp", vn + 1, sv.n)
    `CK("nbuf", bn, sb.n)
    `CK("vdata", 32'h11223344, sv.got[2'(vn)].data)
    `CK("vaddr", 21'h001814, sv.got[2'(vn)].addr)
    for (int r = 0; r < 5; r++)
    begin
      wpix(32'(rsv[r]), 22'h201814, 32'h11223344);
      `CK("dropped", bn + pn + vn, sb.n + sp.n + sv.n)
    end
    bus(1'b0, 22'hc, 32'h0);
    `CK("drop_count", 16'd5, q[15:0])
    $display("test routing done");
    // pipeline mode: constant fill and w source
    bus(1'b1, 22'h4, 32'h00020000);
    wpix(32'h104, 22'h201814, 32'h00112233);
    `CK("npipe", pn + 1, sp.n)
    `CK("y", 10'd476, sp.got[2'(pn)].y)
    `CK("nbuf", bn, sb.n)
    `CK("alpha", 8'h5a, sp.got[2'(pn)].argb[31:24])
    `CK("z", 16'h3456, sp.got[2'(pn)].depth[15:0])
    for (int w = 0; w < 2; w++)
    begin
      wpix(32'h10c | (w << 14), 22'h201814, 32'hbeef0000);
      `CK("w", w ? 16'h3456 : 16'hbeef, sp.got[2'(pn)].w[15:0])
      `CK("zwe", 1'b1, sp.got[2'(pn)].depth_we)
    end
    $display("test pipeline done");
    conclude();
  end
endmodule
